// file: rtl/i2s_slave.sv
// i2s_slave: slave-only two-wire serial port with receive FIFO and transmit holding register
// assumes an external master clocks the bus; link_clk oversamples the bus pins
`timescale 1ns/1ps
`default_nettype none
module i2s_slave #(
   parameter int FIFO_DEPTH = i2s_pkg::RX_FIFO_DEPTH
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic link_clk,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic addr_sel,
   input wire logic test_unlock,
   input wire logic interface_supply_undervoltage_level,
   input wire logic system_supply_undervoltage_level,
   output logic rx_valid,
   input wire logic rx_ready,
   output i2s_pkg::i2s_rx_word_t rx_word,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data
);
   // link-domain reset from the system reset; pins and straps: two flops each
   localparam int NIN = 6;
   logic lrst_m, lrst;
   logic [NIN-1:0] pin_m, pin_s;
   always_ff @(posedge link_clk) begin
      lrst_m <= rst;
      lrst <= lrst_m;
      pin_m <= {interface_supply_undervoltage_level, system_supply_undervoltage_level,
                test_unlock, addr_sel, sda_i, scl_i};
      pin_s <= pin_m;
   end

   // spike filter per bus line: output follows only a stable input
   logic hs_q, hs_d;
   logic [3:0] filt_len;
   logic [1:0] filt_q, prev_q;
   assign filt_len = hs_q ? i2s_pkg::FILT_HS_CYC : i2s_pkg::FILT_FS_CYC;
   generate
      for (genvar g = 0; g < 2; g++) begin : g_filt
         logic f_q, f_d, p_q;
         logic [3:0] c_q, c_d;
         always_comb begin
            f_d = f_q;
            c_d = 4'h0;
            if (pin_s[g] != f_q) begin
               c_d = c_q + 4'h1;
               if (c_d >= filt_len) begin
                  f_d = pin_s[g];
                  c_d = 4'h0;
               end
            end
         end
         always_ff @(posedge link_clk) begin
            if (lrst) begin
               f_q <= 1'b1;
               c_q <= 4'h0;
               p_q <= 1'b1;
            end else begin
               f_q <= f_d;
               c_q <= c_d;
               p_q <= f_q;
            end
         end
         assign filt_q[g] = f_q;
         assign prev_q[g] = p_q;
      end
   endgenerate

   logic scl_f, sda_f, scl_p, sda_p;
   logic scl_rise, scl_fall, start_ev, stop_ev;
   assign scl_f = filt_q[0];
   assign sda_f = filt_q[1];
   assign scl_p = prev_q[0];
   assign sda_p = prev_q[1];
   assign scl_rise = scl_f & ~scl_p;
   assign scl_fall = ~scl_f & scl_p;
   // data edges while the clock stays high are control, not data
   assign start_ev = scl_f & scl_p & sda_p & ~sda_f;
   assign stop_ev = scl_f & scl_p & ~sda_p & sda_f;

   // crossing flags between the domains
   logic rx_tog_q, rx_tog_d, rx_ack_q, rx_ack_d, tx_tog_q, tx_tog_d, tx_seen_q, tx_seen_d;
   logic tx_full_q, tx_full_d, rx_first_q, rx_first_d;
   logic [7:0] tx_hold_q, tx_hold_d, rx_hold_q, rx_hold_d;
   logic [1:0] lk_m, lk_s, sy_m, sy_s;
   always_ff @(posedge link_clk) begin
      lk_m <= {tx_full_q, rx_ack_q};
      lk_s <= lk_m;
   end
   always_ff @(posedge sys_clk) begin
      sy_m <= {tx_tog_q, rx_tog_q};
      sy_s <= sy_m;
   end

   // address match on the configured addresses only
   logic [6:0] main_addr;
   logic addr_hit;
   logic [7:0] sh_q, sh_d;
   assign main_addr = pin_s[2] ? i2s_pkg::ADDR_MAIN_HI : i2s_pkg::ADDR_MAIN_LO;
   assign addr_hit = (sh_q[7:1] == main_addr) ||
                     (pin_s[3] && (sh_q[7:1] == i2s_pkg::ADDR_TEST));

   // link engine; a slave, it only reacts to edges the master makes
   i2s_pkg::i2s_state_t st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic drv_q, drv_d, rw_q, rw_d, first_q, first_d, mack_q, mack_d;
   logic tx_used_q, tx_used_d;
   logic rx_busy, tx_avail;
   logic [7:0] tx_next;
   assign rx_busy = rx_tog_q != lk_s[0];
   assign tx_avail = lk_s[1] & ~tx_used_q;
   assign tx_next = tx_avail ? tx_hold_q : i2s_pkg::TX_IDLE_BYTE;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      drv_d = drv_q;
      rw_d = rw_q;
      first_d = first_q;
      mack_d = mack_q;
      hs_d = hs_q;
      rx_tog_d = rx_tog_q;
      rx_hold_d = rx_hold_q;
      rx_first_d = rx_first_q;
      tx_tog_d = tx_tog_q;
      tx_used_d = tx_used_q & lk_s[1];
      if (stop_ev) begin
         st_d = i2s_pkg::ST_IDLE;
         drv_d = 1'b0;
         hs_d = 1'b0;
      end else if (start_ev) begin
         // repeated start behaves as a start and keeps the filter speed
         st_d = i2s_pkg::ST_ADDR;
         cnt_d = 4'h0;
         drv_d = 1'b0;
      end else begin
         case (st_q)
            i2s_pkg::ST_IDLE, i2s_pkg::ST_SKIP: begin
               drv_d = 1'b0;
            end
            i2s_pkg::ST_ADDR, i2s_pkg::ST_RX: begin
               if (scl_rise) begin
                  sh_d = {sh_q[6:0], sda_f};
                  cnt_d = cnt_q + 4'h1;
               end
               // decide at the fall ending the eighth bit, so the ack is set up early
               if (scl_fall && cnt_q == i2s_pkg::BITS_PER_BYTE) begin
                  cnt_d = 4'h0;
                  if (st_q == i2s_pkg::ST_ADDR) begin
                     if (sh_q[7:3] == i2s_pkg::HS_CODE) begin
                        hs_d = 1'b1;
                        st_d = i2s_pkg::ST_SKIP;
                     end else if (addr_hit) begin
                        rw_d = sh_q[0];
                        first_d = ~sh_q[0];
                        drv_d = 1'b1;
                        st_d = i2s_pkg::ST_AACK;
                     end else begin
                        st_d = i2s_pkg::ST_SKIP;
                     end
                  end else if (!rx_busy) begin
                     // free path: the byte is handed across and acknowledged; a busy path refuses it
                     rx_hold_d = sh_q;
                     rx_first_d = first_q;
                     first_d = 1'b0;
                     rx_tog_d = ~rx_tog_q;
                     drv_d = 1'b1;
                     st_d = i2s_pkg::ST_RACK;
                  end else begin
                     st_d = i2s_pkg::ST_SKIP;
                  end
               end
            end
            i2s_pkg::ST_AACK, i2s_pkg::ST_RACK: begin
               if (scl_fall) begin
                  cnt_d = 4'h0;
                  if (rw_q) begin
                     sh_d = tx_next;
                     drv_d = ~tx_next[7];
                     tx_used_d = tx_used_q | tx_avail;
                     tx_tog_d = tx_tog_q ^ tx_avail;
                     st_d = i2s_pkg::ST_TX;
                  end else begin
                     drv_d = 1'b0;
                     st_d = i2s_pkg::ST_RX;
                  end
               end
            end
            i2s_pkg::ST_TX: begin
               if (scl_fall) begin
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == i2s_pkg::BITS_PER_BYTE - 4'h1) begin
                     drv_d = 1'b0; // release for the master's ack bit
                     st_d = i2s_pkg::ST_TACK;
                  end else begin
                     sh_d = {sh_q[6:0], 1'b0};
                     drv_d = ~sh_q[6];
                  end
               end
            end
            i2s_pkg::ST_TACK: begin
               if (scl_rise) begin
                  mack_d = ~sda_f;
               end
               if (scl_fall) begin
                  cnt_d = 4'h0;
                  if (mack_q) begin
                     sh_d = tx_next;
                     drv_d = ~tx_next[7];
                     tx_used_d = tx_used_q | tx_avail;
                     tx_tog_d = tx_tog_q ^ tx_avail;
                     st_d = i2s_pkg::ST_TX;
                  end else begin
                     st_d = i2s_pkg::ST_SKIP;
                  end
               end
            end
            default: begin
               st_d = i2s_pkg::ST_IDLE;
               drv_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk) begin
      if (lrst) begin
         st_q <= i2s_pkg::ST_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         drv_q <= 1'b0;
         rw_q <= 1'b0;
         first_q <= 1'b0;
         mack_q <= 1'b0;
         hs_q <= 1'b0;
         rx_tog_q <= 1'b0;
         rx_hold_q <= 8'h00;
         rx_first_q <= 1'b0;
         tx_tog_q <= 1'b0;
         tx_used_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         drv_q <= drv_d;
         rw_q <= rw_d;
         first_q <= first_d;
         mack_q <= mack_d;
         hs_q <= hs_d;
         rx_tog_q <= rx_tog_d;
         rx_hold_q <= rx_hold_d;
         rx_first_q <= rx_first_d;
         tx_tog_q <= tx_tog_d;
         tx_used_q <= tx_used_d;
      end
   end

   // open-drain pins; released when both supplies are low
   assign scl_o = 1'b0;
   assign scl_oe = 1'b0;
   assign sda_o = 1'b0;
   assign sda_oe = drv_q & ~(pin_s[5] & pin_s[4]);

   // system side: receive crossing into the FIFO, transmit holding register
   logic rx_pend, fifo_in_ready;
   i2s_pkg::i2s_rx_word_t fifo_in;
   assign rx_pend = sy_s[0] != rx_ack_q;
   // byte stays stable in the link domain until the ack toggle returns
   assign fifo_in = '{first: rx_first_q, data: rx_hold_q};
   assign tx_ready = ~tx_full_q;

   always_comb begin
      rx_ack_d = rx_ack_q ^ (rx_pend & fifo_in_ready);
      tx_seen_d = sy_s[1];
      tx_full_d = tx_full_q;
      tx_hold_d = tx_hold_q;
      if (sy_s[1] != tx_seen_q) begin
         tx_full_d = 1'b0;
      end else if (tx_valid && !tx_full_q) begin
         tx_full_d = 1'b1;
         tx_hold_d = tx_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx_ack_q <= 1'b0;
         tx_seen_q <= 1'b0;
         tx_full_q <= 1'b0;
         tx_hold_q <= 8'h00;
      end else begin
         rx_ack_q <= rx_ack_d;
         tx_seen_q <= tx_seen_d;
         tx_full_q <= tx_full_d;
         tx_hold_q <= tx_hold_d;
      end
   end

   i2s_fifo #(
      .WIDTH($bits(i2s_pkg::i2s_rx_word_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .clk(sys_clk),
      .rst(rst),
      .in_valid(rx_pend),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_word)
   );
endmodule
`default_nettype wire

// file: rtl/i2s_pkg.sv
// i2s_pkg: constants and carrier types for the two-wire slave port
// assumes a 20 MHz system clock and a separate link sampling clock
package i2s_pkg;
   // slave addresses (7-bit)
   localparam logic [6:0] ADDR_MAIN_HI = 7'h48;
   localparam logic [6:0] ADDR_MAIN_LO = 7'h40;
   localparam logic [6:0] ADDR_TEST = 7'h49;
   // high-speed master code pattern, upper five bits
   localparam logic [4:0] HS_CODE = 5'h01;
   // bits per data packet before the acknowledge bit
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // byte sent when no transmit data is waiting
   localparam logic [7:0] TX_IDLE_BYTE = 8'hff;
   // input spike filter spans, longest times, in ns
   localparam int FILT_FS_NS = 50;
   localparam int FILT_HS_NS = 10;
   localparam int LINK_CLK_HZ = 8_000_000;
   localparam int FILT_FS_RAW = (FILT_FS_NS * (LINK_CLK_HZ / 1_000_000)) / 1000;
   localparam int FILT_HS_RAW = (FILT_HS_NS * (LINK_CLK_HZ / 1_000_000)) / 1000;
   localparam logic [3:0] FILT_FS_CYC = (FILT_FS_RAW < 1) ? 4'h1 : 4'(FILT_FS_RAW);
   localparam logic [3:0] FILT_HS_CYC = (FILT_HS_RAW < 1) ? 4'h1 : 4'(FILT_HS_RAW);
   localparam int RX_FIFO_DEPTH = 8;

   typedef struct packed {
      logic first;
      logic [7:0] data;
   } i2s_rx_word_t;

   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_ADDR = 8'h02,
      ST_AACK = 8'h04,
      ST_RX = 8'h08,
      ST_RACK = 8'h10,
      ST_TX = 8'h20,
      ST_TACK = 8'h40,
      ST_SKIP = 8'h80
   } i2s_state_t;
endpackage

// file: rtl/i2s_fifo.sv
// i2s_fifo: flip-flop FIFO, width and depth as parameters
// assumes one clock; push and pop by valid and ready on each side
`timescale 1ns/1ps
`default_nettype none
module i2s_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [AW:0] wr_q, wr_d, rd_q, rd_d;
   logic push, pop, full, empty;

   assign empty = (wr_q == rd_q);
   assign full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign out_data = mem_q[rd_q[AW-1:0]];
   assign push = in_valid & ~full;
   assign pop = out_ready & ~empty;

   always_comb begin
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      if (push) begin
         mem_d[wr_q[AW-1:0]] = in_data;
         wr_d = wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = rd_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         mem_q <= mem_d;
      end
   end
endmodule
`default_nettype wire

// file: verification/i2s_slave_properties.sv
// i2s_slave_properties: port-level checks for the two-wire slave port
// assumes it is bound onto i2s_slave and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module i2s_slave_properties #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic link_clk,
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic addr_sel,
   input wire logic test_unlock,
   input wire logic interface_supply_undervoltage_level,
   input wire logic system_supply_undervoltage_level,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire i2s_pkg::i2s_rx_word_t rx_word,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [7:0] tx_data
);
   // link cycles since the clock line went low, saturating
   logic [3:0] low_cnt_q;
   logic [3:0] low_cnt_d;
   always_comb begin
      low_cnt_d = scl_i ? 4'h0 : ((low_cnt_q == 4'hf) ? low_cnt_q : low_cnt_q + 4'h1);
   end
   always_ff @(posedge link_clk) begin
      low_cnt_q <= low_cnt_d;
   end

   scl_never_driven_a: assert property (@(posedge sys_clk) disable iff (rst)
      !scl_oe && !scl_o)
      else $error("clock line driven by the port");
   sda_low_only_a: assert property (@(posedge link_clk) disable iff (rst) !sda_o)
      else $error("data line driven high");
   supply_release_a: assert property (@(posedge link_clk) disable iff (rst)
      (interface_supply_undervoltage_level && system_supply_undervoltage_level) [*5] |-> !sda_oe)
      else $error("data line driven with both supplies low");
   sda_hold_high_a: assert property (@(posedge link_clk) disable iff (rst)
      scl_i && $past(scl_i) |-> $stable(sda_oe))
      else $error("data drive changed while clock high");
   sda_after_fall_a: assert property (@(posedge link_clk) disable iff (rst)
      $changed(sda_oe) |-> low_cnt_q inside {[2:8]})
      else $error("data drive changed away from a clock fall");
   no_false_start_a: assert property (@(posedge link_clk) disable iff (rst)
      $rose(sda_oe) |-> !scl_i)
      else $error("data pulled low while clock high");
   tx_take_a: assert property (@(posedge sys_clk) disable iff (rst)
      tx_valid && tx_ready |=> !tx_ready)
      else $error("transmit byte not taken");
   rx_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
      else $error("receive word dropped while stalled");
   reset_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(rst) |-> !rx_valid && tx_ready)
      else $error("port not idle after reset");
endmodule
`default_nettype wire

// file: verification/i2s_master_model.sv
// i2s_master_model: behavioural bus master on the open-drain pair
// assumes the bench resolves both lines with pull-ups; pull high = drive low
`timescale 1ns/1ps
`default_nettype none
module i2s_master_model #(
   parameter int QTR_NS = 1000
) (
   input wire logic scl,
   input wire logic sda,
   output logic scl_pull,
   output logic sda_pull
);
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end
   // start or repeated start, ends with clock low
   task automatic start_cond();
      #QTR_NS sda_pull = 1'b0;
      #QTR_NS scl_pull = 1'b0;
      #QTR_NS sda_pull = 1'b1;
      #QTR_NS scl_pull = 1'b1;
   endtask
   task automatic stop_cond();
      #QTR_NS sda_pull = 1'b1;
      #QTR_NS scl_pull = 1'b0;
      #QTR_NS sda_pull = 1'b0;
      #QTR_NS;
   endtask
   // data set a quarter after the fall, so it never moves with clock high
   task automatic bit_xfer(input logic b, output logic seen);
      #QTR_NS sda_pull = !b;
      #QTR_NS scl_pull = 1'b0;
      #QTR_NS seen = sda;
      #QTR_NS scl_pull = 1'b1;
   endtask
   // eight bits msb first, then the acknowledge bit
   task automatic byte_xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] got,
         output logic ack_seen);
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(d[i], got[i]);
      end
      bit_xfer(ack_in, ack_seen);
   endtask
endmodule
`default_nettype wire

// file: verification/test_i2c_slave_serial_port.sv
// test_i2c_slave_serial_port: self-checking bench for the two-wire slave port
// assumes i2s_slave, its package and the master model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_i2c_slave_serial_port;
   logic sys_clk, link_clk, rst, scl_pull, sda_pull, scl_w, sda_w, scl_o, scl_oe, sda_o, sda_oe;
   logic addr_sel, test_unlock, io_uv, sys_uv, rx_valid, rx_ready, tx_valid, tx_ready;
   logic drain, ack, seen;
   logic [7:0] tx_data, got, b;
   logic [31:0] lfsr_q;
   i2s_pkg::i2s_rx_word_t rx_word;
   i2s_pkg::i2s_rx_word_t exp_q[$];
   int bad_count, checked, n;
   // {addr, strap, unlock, io low, sys low, ack expected}
   logic [11:0] tbl [8] = '{12'h915, 12'h801, 12'h900, 12'h939, 12'h930, 12'h010, 12'h090,
      12'h916};

   assign scl_w = ~(scl_pull | scl_oe);
   assign sda_w = ~(sda_pull | sda_oe);

   i2s_slave #(.FIFO_DEPTH(8)) DUT (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk),
      .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe(sda_oe), .addr_sel(addr_sel), .test_unlock(test_unlock),
      .interface_supply_undervoltage_level(io_uv), .system_supply_undervoltage_level(sys_uv),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_data(tx_data));
   i2s_master_model m (.scl(scl_w), .sda(sda_w), .scl_pull(scl_pull), .sda_pull(sda_pull));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [8:0] seen_v, input logic [8:0] exp_v);
      checked++;
      if (seen_v !== exp_v) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen_v, exp_v);
      end
   endtask
   task automatic results();
      $display("mismatches %0d, comparisons %0d", bad_count, checked);
      if (bad_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic send(input logic [7:0] d, output logic a);
      m.byte_xfer(d, 1'b1, got, seen);
      a = !seen;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      link_clk = 1'b0;
      #37;
      forever #62.5 link_clk = ~link_clk;
   end
   // random stalls on the receive side while draining
   always @(posedge sys_clk) begin
      lfsr_q <= lfsr_next(lfsr_q);
      rx_ready <= drain & lfsr_q[0];
   end
   always @(posedge sys_clk) begin
      if (rst === 1'b0 && rx_valid === 1'b1 && rx_ready === 1'b1) begin
         check(rx_word, (exp_q.size() != 0) ? exp_q.pop_front() : 9'hx);
      end
   end
   initial begin
      #3_000_000;
      bad_count++;
      results();
   end

   initial begin
      {rst, addr_sel, test_unlock, io_uv, sys_uv, drain, tx_valid, rx_ready} = 8'hc0;
      tx_data = 8'h00;
      lfsr_q = 32'h7a3d;
      bad_count = 0;
      checked = 0;
      // longer than ten cycles: the link side needs four of its own edges
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      #1 check({7'h0, rx_valid, tx_ready}, 9'h001);
      foreach (tbl[i]) begin
         @(posedge sys_clk);
         {addr_sel, test_unlock, io_uv, sys_uv} <= tbl[i][4:1];
         repeat (20) @(posedge sys_clk);
         m.start_cond();
         send({tbl[i][11:5], 1'b0}, ack);
         check({8'h0, ack}, {8'h0, tbl[i][0]});
         m.stop_cond();
      end
      @(posedge sys_clk);
      {addr_sel, test_unlock, io_uv, sys_uv} <= 4'h8;
      repeat (20) @(posedge sys_clk);
      m.start_cond();
      send(8'h90, ack);
      check({8'h0, ack}, 9'h001);
      n = 0;
      while (ack && n < 12) begin
         b = lfsr_q[15:8];
         send(b, ack);
         if (ack) exp_q.push_back({n == 0, b});
         n++;
      end
      check({7'h0, ack, n > 8}, 9'h001);
      @(posedge sys_clk);
      b = lfsr_q[23:16];
      tx_valid <= 1'b1;
      tx_data <= b;
      @(posedge sys_clk);
      tx_valid <= 1'b0;
      m.start_cond();
      send(8'h91, ack);
      check({8'h0, ack}, 9'h001);
      m.byte_xfer(8'hff, 1'b0, got, seen);
      check({1'b0, got}, {1'b0, b});
      m.byte_xfer(8'hff, 1'b1, got, seen);
      check({1'b0, got}, {1'b0, i2s_pkg::TX_IDLE_BYTE});
      m.stop_cond();
      @(posedge sys_clk);
      drain <= 1'b1;
      n = 0;
      while ((rx_valid !== 1'b0 || exp_q.size() != 0) && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
      check({8'h0, rx_valid}, 9'(exp_q.size()));
      results();
   end
endmodule
`default_nettype wire

bind i2s_slave i2s_slave_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.sys_clk(sys_clk),
   .rst(rst), .link_clk(link_clk), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
   .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .addr_sel(addr_sel),
   .test_unlock(test_unlock),
   .interface_supply_undervoltage_level(interface_supply_undervoltage_level),
   .system_supply_undervoltage_level(system_supply_undervoltage_level),
   .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word), .tx_valid(tx_valid),
   .tx_ready(tx_ready), .tx_data(tx_data));
